// *** design/gpio_ports.sv ***
/*
 Dual-port GPIO: a six-pin first port with an input-only pin and a shared
 oscillator clock output, and an eight-pin second port, each with data
 latches, direction bits and pull-up enables, reached over AHB-Lite.
 Assumes one AHB-Lite master, single word transfers, and that the pad
 resolves pin level from output enable (low = driving) and pull request.
*/
`timescale 1ns/1ps
module gpio_ports (
  input wire logic hclk, // Bus clock, 125 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic four_times_bus_clock, // Oscillator clock to pin
  input wire logic [5:0] first_port_pin_in, // First port pin levels
  output logic [5:0] first_port_pin_out, // First port pin drive level
  output logic [5:0] first_port_pin_oe_n, // First port drive, low=on
  output logic [5:0] first_port_pullup, // First port pull-up on
  input wire logic [7:0] second_port_pin_in, // Second port pin levels
  output logic [7:0] second_port_pin_out, // Second port drive level
  output logic [7:0] second_port_pin_oe_n, // Second port drive, low=on
  output logic [7:0] second_port_pullup // Second port pull-up on
);
  localparam int unsigned fw = gpio_pkg::first_width;
  localparam int unsigned sw = gpio_pkg::second_width;

  logic [fw-1:0] first_port_data_q;
  logic [fw-1:0] first_port_direction_q;
  logic [fw-1:0] first_port_pullup_enable_q;
  logic [sw-1:0] second_port_data_q;
  logic [sw-1:0] second_port_direction_q;
  logic [sw-1:0] second_port_pullup_enable_q;
  logic [3:0] clock_ctrl_q;
  logic [fw-1:0] first_sync;
  logic [sw-1:0] second_sync;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_d;
  logic access;
  logic [7:0] addr_ph;
  logic clock_output_pin_enable;
  logic [1:0] osc_opt;
  logic irq_en;
  logic osc_pin_is_clock;
  logic [fw-1:0] first_drive;
  logic [fw-1:0] first_read;
  gpio_pkg::pin_drive_t first_drv;
  gpio_pkg::pin_drive_t second_drv;

  pin_sync #(.width(fw)) u_first_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .pin_in(first_port_pin_in),
    .pin_sync_q(first_sync)
  );

  pin_sync #(.width(sw)) u_second_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .pin_in(second_port_pin_in),
    .pin_sync_q(second_sync)
  );

  assign clock_output_pin_enable = clock_ctrl_q[gpio_pkg::clk_out_en_pos];
  assign osc_opt = clock_ctrl_q[gpio_pkg::osc_opt_pos +: 2];
  assign irq_en = clock_ctrl_q[gpio_pkg::irq_en_pos];

  // Zero-wait-state slave: address phase captured, data phase next cycle
  assign access = hsel && hready && (htrans == gpio_pkg::htrans_nonseq);
  assign addr_ph = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce && hready) begin
      wr_pend_q <= access && hwrite;
      rd_pend_q <= access && !hwrite;
      addr_q <= addr_ph;
    end
  end

  // Data latches have no reset; writes land whatever the direction
  always_ff @(posedge hclk) begin
    if (ce && wr_pend_q && addr_q == gpio_pkg::first_data_off) begin
      first_port_data_q <= hwdata[fw-1:0];
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && wr_pend_q && addr_q == gpio_pkg::second_data_off) begin
      second_port_data_q <= hwdata[sw-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_port_direction_q <= gpio_pkg::first_dir_rst;
    end else if (ce && wr_pend_q && addr_q == gpio_pkg::first_dir_off) begin
      first_port_direction_q <= hwdata[fw-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_port_pullup_enable_q <= gpio_pkg::first_pue_rst;
    end else if (ce && wr_pend_q && addr_q == gpio_pkg::first_pue_off) begin
      first_port_pullup_enable_q <= hwdata[fw-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_port_direction_q <= gpio_pkg::second_dir_rst;
    end else if (ce && wr_pend_q && addr_q == gpio_pkg::second_dir_off) begin
      second_port_direction_q <= hwdata[sw-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_port_pullup_enable_q <= gpio_pkg::second_pue_rst;
    end else if (ce && wr_pend_q && addr_q == gpio_pkg::second_pue_off) begin
      second_port_pullup_enable_q <= hwdata[sw-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_ctrl_q <= gpio_pkg::clock_ctrl_rst;
    end else if (ce && wr_pend_q && addr_q == gpio_pkg::clock_ctrl_off) begin
      clock_ctrl_q <= hwdata[3:0];
    end
  end

  // Clock out only for internal or RC oscillator options
  assign osc_pin_is_clock = clock_output_pin_enable &&
    (osc_opt == gpio_pkg::osc_internal || osc_opt == gpio_pkg::osc_rc);

  always_comb begin
    first_drive = first_port_direction_q;
    first_drive[gpio_pkg::input_only_bit] = 1'b0;
    if (osc_pin_is_clock) begin
      first_drive[gpio_pkg::bit_four] = 1'b1;
    end
  end

  always_comb begin
    first_drv = '0;
    first_drv.oe_n[fw-1:0] = ~first_drive;
    first_drv.dout[fw-1:0] = first_port_data_q;
    if (osc_pin_is_clock) begin
      first_drv.dout[gpio_pkg::bit_four] = four_times_bus_clock;
    end
    // Pull-up only where enabled and the direction bit is clear
    first_drv.pull[fw-1:0] = first_port_pullup_enable_q &
      ~first_port_direction_q;
    if (osc_pin_is_clock) begin
      first_drv.pull[gpio_pkg::bit_four] = 1'b0;
    end
  end

  always_comb begin
    second_drv = '0;
    second_drv.oe_n = ~second_port_direction_q;
    second_drv.dout = second_port_data_q;
    second_drv.pull = second_port_pullup_enable_q &
      ~second_port_direction_q;
  end

  assign first_port_pin_out = first_drv.dout[fw-1:0];
  assign first_port_pin_oe_n = first_drv.oe_n[fw-1:0];
  assign first_port_pullup = first_drv.pull[fw-1:0];
  assign second_port_pin_out = second_drv.dout;
  assign second_port_pin_oe_n = second_drv.oe_n;
  assign second_port_pullup = second_drv.pull;

  always_comb begin
    first_read = (first_port_direction_q & first_port_data_q) |
      (~first_port_direction_q & first_sync);
    // Input-only pin has no driver, so report its level unless irq_en is set, which reads it as 0
    first_read[gpio_pkg::input_only_bit] = irq_en ? 1'b0 :
      first_sync[gpio_pkg::input_only_bit];
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (addr_ph)
      gpio_pkg::first_data_off: rd_d[fw-1:0] = first_read;
      gpio_pkg::first_dir_off: rd_d[fw-1:0] = first_port_direction_q;
      gpio_pkg::first_pue_off: rd_d[fw-1:0] = first_port_pullup_enable_q;
      gpio_pkg::second_data_off: rd_d[sw-1:0] =
        (second_port_direction_q & second_port_data_q) |
        (~second_port_direction_q & second_sync);
      gpio_pkg::second_dir_off: rd_d[sw-1:0] = second_port_direction_q;
      gpio_pkg::second_pue_off: rd_d[sw-1:0] = second_port_pullup_enable_q;
      gpio_pkg::clock_ctrl_off: rd_d[3:0] = clock_ctrl_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data sampled at end of address phase, held through data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && access && !hwrite) begin
      hrdata_q <= rd_d;
    end
  end

  assign hrdata = hrdata_q;
endmodule : gpio_ports

// *** design/gpio_pkg.sv ***
/*
 Package for the dual-port GPIO block: register offsets, field positions,
 reset values and bus encodings.
 Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
*/
package gpio_pkg;
  localparam int unsigned first_width = 6;
  localparam int unsigned second_width = 8;
  // Byte offsets of the register words
  localparam logic [7:0] first_data_off = 8'h00;
  localparam logic [7:0] first_dir_off = 8'h04;
  localparam logic [7:0] first_pue_off = 8'h08;
  localparam logic [7:0] second_data_off = 8'h0c;
  localparam logic [7:0] second_dir_off = 8'h10;
  localparam logic [7:0] second_pue_off = 8'h14;
  localparam logic [7:0] clock_ctrl_off = 8'h18;
  // Field positions
  localparam int unsigned input_only_bit = 2;
  localparam int unsigned bit_four = 4;
  localparam int unsigned clk_out_en_pos = 0;
  localparam int unsigned osc_opt_pos = 1;
  localparam int unsigned irq_en_pos = 3;
  // Reset values
  localparam logic [5:0] first_dir_rst = 6'h00;
  localparam logic [5:0] first_pue_rst = 6'h00;
  localparam logic [7:0] second_dir_rst = 8'h00;
  localparam logic [7:0] second_pue_rst = 8'h00;
  localparam logic [3:0] clock_ctrl_rst = 4'h0;
  // Oscillator options and bus encodings
  localparam logic [1:0] osc_internal = 2'h0;
  localparam logic [1:0] osc_external = 2'h1;
  localparam logic [1:0] osc_rc = 2'h2;
  localparam logic [1:0] osc_crystal = 2'h3;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;

  typedef struct packed {
    logic [7:0] pull;
    logic [7:0] oe_n;
    logic [7:0] dout;
  } pin_drive_t;
endpackage : gpio_pkg

// *** design/pin_sync.sv ***
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the pins are asynchronous to hclk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned width = 8
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [width-1:0] pin_in, // Raw pin levels
  output logic [width-1:0] pin_sync_q // Synchronised levels
);
  logic [width-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      pin_sync_q <= '0;
    end else if (ce) begin
      meta_q <= pin_in;
      pin_sync_q <= meta_q;
    end
  end
endmodule : pin_sync

// *** bench/gpio_pin_model.sv ***
/* Far side of the GPIO pins: resolves each pin level.
   Assumes device drive wins over an external source. */
`timescale 1ns/1ps
module gpio_pin_model (
  input wire logic hclk, // Clock
  input wire logic [13:0] dout, // Device level
  input wire logic [13:0] oe_n, // Drive, low=on
  input wire logic [13:0] pull, // Pull-up on
  input wire logic [13:0] ext_en, // Source on
  input wire logic [13:0] ext_val, // Source level
  output logic [13:0] pin // Pin level
);
  logic [13:0] float_q = 14'h0000;
  // A pin nobody holds flips every cycle
  always @(posedge hclk) begin
    float_q <= ~float_q;
  end
  assign pin = (~oe_n & dout) | (oe_n & ext_en & ext_val)
    | (oe_n & ~ext_en & (pull | float_q));
endmodule : gpio_pin_model

// *** bench/gpio_ports_assertions.sv ***
/* Checker on the gpio_ports ports.
   Bound to every gpio_ports; one clock domain. */
`timescale 1ns/1ps
module gpio_ports_assertions (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic ce, // Enable
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Data
  input wire logic hready, // Ready
  input wire logic hresp, // Response
  input wire logic [5:0] first_port_pin_oe_n, // Drive
  input wire logic [5:0] first_port_pullup, // Pull
  input wire logic [7:0] second_port_pin_out, // Level
  input wire logic [7:0] second_port_pin_oe_n, // Drive
  input wire logic [7:0] second_port_pullup // Pull
);
  logic wr_q;
  logic [7:0] off_q;
  logic [7:0] wd_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Write taken in the address phase, seen in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      off_q <= 8'h00;
    end else if (ce) begin
      wr_q <= hsel && hready && hwrite && htrans == gpio_pkg::htrans_nonseq;
      off_q <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk) begin
    wd_q <= hwdata[7:0];
  end
  first_pull_off_a: assert property (
    (first_port_pullup & ~first_port_pin_oe_n) == 6'h00) else $error("pull");
  second_pull_off_a: assert property (
    (second_port_pullup & ~second_port_pin_oe_n) == 8'h00) else $error("pull");
  input_only_a: assert property (
    first_port_pin_oe_n[2]) else $error("input-only pin driven");
  reset_dir_a: assert property ($rose(hresetn) |->
    &{first_port_pin_oe_n, second_port_pin_oe_n}) else $error("reset dir");
  dir_lands_a: assert property (
    wr_q && ce && off_q == gpio_pkg::second_dir_off
    |=> second_port_pin_oe_n == ~wd_q) else $error("direction write");
  pue_lands_a: assert property (
    wr_q && ce && off_q == gpio_pkg::second_pue_off
    |=> second_port_pullup == (wd_q & second_port_pin_oe_n))
    else $error("pue");
  data_lands_a: assert property (
    wr_q && ce && off_q == gpio_pkg::second_data_off
    |=> second_port_pin_out == wd_q) else $error("data write");
  dir_holds_a: assert property (
    !(wr_q && off_q == gpio_pkg::second_dir_off)
    |=> $stable(second_port_pin_oe_n)) else $error("direction moved");
  okay_resp_a: assert property (
    !hresp) else $error("response not okay");
  cover property (wr_q && off_q == gpio_pkg::second_dir_off);
  cover property (wr_q && off_q == gpio_pkg::second_pue_off);
  cover property ($rose(hresetn));
  cover property (!ce && hsel && htrans == gpio_pkg::htrans_nonseq);
endmodule : gpio_ports_assertions
bind gpio_ports gpio_ports_assertions i_chk (.hclk(hclk),
  .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hresp(hresp),
  .first_port_pin_oe_n(first_port_pin_oe_n),
  .first_port_pullup(first_port_pullup),
  .second_port_pin_out(second_port_pin_out),
  .second_port_pin_oe_n(second_port_pin_oe_n),
  .second_port_pullup(second_port_pullup));

// *** bench/gpio_ports_tb.sv ***
/* Bench for gpio_ports over AHB-Lite, pins on gpio_pin_model.
   Assumes one master and zero-wait answers. */
`timescale 1ns/1ps
module gpio_ports_tb;
  logic hclk = 1'b0;
  logic fclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [13:0] ext_en = 14'h3fff;
  logic [13:0] ext_val = 14'h0000;
  logic [31:0] d, r, p, c, e, en, lv, x;
  logic a;
  wire [31:0] hrdata;
  wire hreadyout;
  wire [13:0] dout, oe_n, pull, pins;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  initial forever #4 hclk = ~hclk;
  initial forever #1 fclk = ~fclk;
  gpio_ports i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(gpio_pkg::hsize_word), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .four_times_bus_clock(fclk), .first_port_pin_in(pins[5:0]),
    .first_port_pin_out(dout[5:0]), .first_port_pin_oe_n(oe_n[5:0]),
    .first_port_pullup(pull[5:0]), .second_port_pin_in(pins[13:6]),
    .second_port_pin_out(dout[13:6]), .second_port_pin_oe_n(oe_n[13:6]),
    .second_port_pullup(pull[13:6]));
  gpio_pin_model i_pins (.hclk(hclk), .dout(dout), .oe_n(oe_n),
    .pull(pull), .ext_en(ext_en), .ext_val(ext_val), .pin(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] o,
    input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, o};
    hwrite <= w;
    htrans <= gpio_pkg::htrans_nonseq;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    rd_dp <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] o, input logic [31:0] want);
    exp_q.push_back(want);
    xfer(1'b0, o, 32'h0);
  endtask : rd
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Read data is compared at the edge that ends its data phase
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) chk(hrdata, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    results();
  end
  initial begin
    void'($urandom(61));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    for (int k = 0; k < 40; k++) begin
      d = $urandom();
      r = $urandom();
      p = $urandom();
      c = $urandom() & 32'hf;
      e = $urandom();
      a = c[0] && !c[1];
      r[4] = r[4] | a;
      en = $urandom() | ~(p & ~r);
      lv = (en & e) | ~en;
      ext_en <= en[13:0];
      ext_val <= e[13:0];
      xfer(1'b1, gpio_pkg::first_data_off, d);
      xfer(1'b1, gpio_pkg::first_dir_off, r);
      xfer(1'b1, gpio_pkg::first_pue_off, p);
      xfer(1'b1, gpio_pkg::clock_ctrl_off, c);
      xfer(1'b1, gpio_pkg::second_data_off, d >> 6);
      xfer(1'b1, gpio_pkg::second_dir_off, r >> 6);
      xfer(1'b1, gpio_pkg::second_pue_off, p >> 6);
      x = (d & r) | (lv & ~r);
      x[2] = !c[3] & lv[2];
      rd(gpio_pkg::first_data_off, {26'h0, x[5:0]});
      rd(gpio_pkg::second_data_off, {24'h0, x[13:6]});
      rd(gpio_pkg::first_pue_off, {26'h0, p[5:0]});
      #0.5;
      chk({18'h0, pull}, {18'h0, p[13:0] & ~r[13:0]});
      chk({18'h0, oe_n}, {18'h0, ~r[13:0] | 14'h0004});
      chk({18'h0, dout}, {18'h0, d[13:5], a ? fclk : d[4], d[3:0]});
      @(posedge hclk);
    end
    hresetn <= 1'b0;
    #0.5;
    chk({18'h0, oe_n}, 32'h3fff);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, gpio_pkg::second_dir_off, 32'hff);
    rd(gpio_pkg::second_data_off, {24'h0, d[13:6]});
    // A write offered while the enable is low must not land
    ce <= 1'b0;
    xfer(1'b1, gpio_pkg::second_dir_off, 32'h00);
    ce <= 1'b1;
    rd(gpio_pkg::second_dir_off, 32'hff);
    rd(gpio_pkg::second_data_off, {24'h0, d[13:6]});
    @(posedge hclk);
    results();
  end
endmodule : gpio_ports_tb
